// File: rtl/dpcr_pkg.sv
// Package of offsets, field positions and reset values for the port configuration registers
package dpcr_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] DPCR_CHARGE_OFS     = 8'h06; // Charge enable register
   localparam logic [7:0] DPCR_REMOVABLE_OFS  = 8'h07; // Removable configuration register
   localparam logic [7:0] DPCR_PORT_USED_OFS  = 8'h08; // Port-used register
   // -----------------------------------------------------------------
   // Field positions and widths
   // -----------------------------------------------------------------
   localparam int DPCR_PORTS        = 4;               // Downstream ports
   localparam int DPCR_OVERRIDE_BIT = 7;               // Custom override bit
   localparam int DPCR_PORT_LSB     = 0;               // Low per-port field bit
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic       DPCR_OVERRIDE_RST = 1'b0;    // Override off after reset
   localparam logic [3:0] DPCR_USED_RST     = 4'hf;    // All ports used after reset
   localparam logic [3:0] DPCR_LEGACY_RST   = 4'h0;    // No legacy-only port after reset
endpackage : dpcr_pkg

// File: rtl/dpcr_strap_sync.sv
// Two-stage synchroniser for a group of strap or pin levels
`timescale 1ns/1ps
module dpcr_strap_sync #(
   parameter int WIDTH = 4                              // Number of levels
) (
   input  wire logic             core_clk_i,            // Core clock
   input  wire logic             sys_rst_i,             // Async reset, high
   input  wire logic [WIDTH-1:0] async_i,               // Levels from pins
   output logic      [WIDTH-1:0] sync_o                 // Synchronised levels
);
   logic [WIDTH-1:0] stage1_reg;                        // First stage, read only by second
   logic [WIDTH-1:0] stage2_reg;                        // Second stage

   // Width must be usable
   initial begin
      if (WIDTH < 1) begin
         $error("dpcr_strap_sync: WIDTH must be at least one");
      end
   end

   // Plain two-flop chain
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_o = stage2_reg;
endmodule // dpcr_strap_sync

// File: rtl/dpcr_regs.sv
// Per-port configuration registers: charge enable, removable and port-used fields
`timescale 1ns/1ps
module dpcr_regs
   import dpcr_pkg::*;
#(
   parameter int PORTS = DPCR_PORTS                     // Downstream port count
) (
   input  wire logic             core_clk_i,            // Core clock, 100 MHz
   input  wire logic             sys_rst_i,             // Async reset, high
   input  wire logic [PORTS-1:0] power_charge_strap_i,  // Strap pins, asynchronous
   input  wire logic [PORTS-1:0] otp_fixed_attach_i,    // OTP fixed-attach bits, static
   input  wire logic [PORTS-1:0] otp_port_used_i,       // OTP port-used bits, static
   input  wire logic [PORTS-1:0] otp_legacy_only_i,     // OTP legacy-speed-only bits
   input  wire logic             cfg_wr_i,              // Write strobe from config source
   input  wire logic [7:0]       cfg_addr_i,            // Register offset
   input  wire logic [7:0]       cfg_wdata_i,           // Write data
   output logic      [7:0]       cfg_rdata_o,           // Registered read data
   output logic      [PORTS-1:0] charge_port_enable_o,  // Charging features per port
   output logic      [PORTS-1:0] port_removable_o,      // Removable per port
   output logic      [PORTS-1:0] port_enabled_o,        // Effective port enable
   output logic      [PORTS-1:0] legacy_speed_only_o,   // Legacy-speed-only per port
   output logic                  custom_attach_override_o // Override bit state
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      DPCR_ST_RESET,                                    // Sync chain still at reset value
      DPCR_ST_FILL,                                     // Straps moving into second flop
      DPCR_ST_LOAD,                                     // Capture straps
      DPCR_ST_RUN                                       // Normal operation
   } dpcr_state_t;

   dpcr_state_t      state_reg, state_next;             // Start-up sequencer
   logic [PORTS-1:0] charge_reg, charge_next;           // Charge enables
   logic             override_reg, override_next;       // Custom override bit
   logic [PORTS-1:0] rmv_reg, rmv_next;                 // Written removable bits
   logic [PORTS-1:0] used_reg, used_next;               // Written port-used bits
   logic [PORTS-1:0] legacy_reg, legacy_next;           // Legacy-only bits, never written, hold reset value
   logic [7:0]       rdata_reg, rdata_next;             // Read data register
   logic [PORTS-1:0] strap_sync;                        // Synchronised straps
   logic [PORTS-1:0] rmv_eff;                           // Effective removable
   logic [PORTS-1:0] used_eff;                          // Effective port-used field
   logic [PORTS-1:0] enabled_eff;                       // Effective enable

   // Port count is fixed by the 4-bit fields
   initial begin
      if (PORTS != DPCR_PORTS) begin
         $error("dpcr_regs: PORTS must equal four");
      end
   end

   // Straps come from pins, so they cross two flops first
   dpcr_strap_sync #(
      .WIDTH (PORTS)
   ) u_strap_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    (power_charge_strap_i),
      .sync_o     (strap_sync)
   );

   // Address decode, used for both write and read paths
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Fills a byte: per-port field low, rest zero
   function automatic logic [7:0] pad_port(input logic [PORTS-1:0] f);
      pad_port = {{(8-PORTS){1'b0}}, f};
   endfunction

   // -----------------------------------------------------------------
   // Effective field values
   // -----------------------------------------------------------------
   // OTP governs while override is low; removable is the inverted fixed-attach bit
   assign rmv_eff  = override_reg ? rmv_reg : ~otp_fixed_attach_i;
   assign used_eff = override_reg ? used_reg : otp_port_used_i;

   // Legacy-only ports stay enabled; ports one and three never both off
   always_comb begin
      enabled_eff = used_eff | legacy_speed_only_o;
      if (!enabled_eff[0] && !enabled_eff[2]) begin
         enabled_eff[0] = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Writes are dropped until the straps are captured, so a loader racing
   // reset release cannot be overwritten by the strap load.
   always_comb begin
      state_next    = state_reg;
      charge_next   = charge_reg;
      override_next = override_reg;
      rmv_next      = rmv_reg;
      used_next     = used_reg;
      legacy_next   = legacy_reg;
      rdata_next    = rdata_reg;
      case (state_reg)
         // The sync chain is reset with the block, so the straps reach
         // its second flop only on the second edge after release
         DPCR_ST_RESET: begin
            state_next = DPCR_ST_FILL;                   // First flop takes the straps
         end
         DPCR_ST_FILL: begin
            state_next = DPCR_ST_LOAD;                   // Second flop takes the straps
         end
         DPCR_ST_LOAD: begin
            charge_next = strap_sync;
            state_next  = DPCR_ST_RUN;
         end
         DPCR_ST_RUN: begin
            if (cfg_wr_i) begin
               if (hit(cfg_addr_i, DPCR_CHARGE_OFS)) begin
                  charge_next = cfg_wdata_i[DPCR_PORT_LSB +: PORTS];
               end
               if (hit(cfg_addr_i, DPCR_REMOVABLE_OFS)) begin
                  override_next = cfg_wdata_i[DPCR_OVERRIDE_BIT];
                  // New override value decides, so both land from one write
                  if (cfg_wdata_i[DPCR_OVERRIDE_BIT]) begin
                     rmv_next = cfg_wdata_i[DPCR_PORT_LSB +: PORTS];
                  end
               end
               if (hit(cfg_addr_i, DPCR_PORT_USED_OFS) && override_reg) begin
                  used_next = cfg_wdata_i[DPCR_PORT_LSB +: PORTS];
               end
            end
         end
         default: begin
            state_next = DPCR_ST_RESET;
         end
      endcase
      // Read mux; unknown offsets read zero
      if (hit(cfg_addr_i, DPCR_CHARGE_OFS)) begin
         rdata_next = pad_port(charge_reg);
      end else if (hit(cfg_addr_i, DPCR_REMOVABLE_OFS)) begin
         rdata_next = {override_reg, 3'h0, rmv_eff};
      end else if (hit(cfg_addr_i, DPCR_PORT_USED_OFS)) begin
         rdata_next = pad_port(used_eff);
      end else begin
         rdata_next = 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // State registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg    <= DPCR_ST_RESET;
         charge_reg   <= '0;
         override_reg <= DPCR_OVERRIDE_RST;
         rmv_reg      <= '0;
         used_reg     <= DPCR_USED_RST;
         legacy_reg   <= DPCR_LEGACY_RST;
         rdata_reg    <= 8'h00;
      end else begin
         state_reg    <= state_next;
         charge_reg   <= charge_next;
         override_reg <= override_next;
         rmv_reg      <= rmv_next;
         used_reg     <= used_next;
         legacy_reg   <= legacy_next;
         rdata_reg    <= rdata_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Legacy register has no offset here; it only follows OTP or keeps its
   // reset value while override is set.
   assign legacy_speed_only_o      = override_reg ? legacy_reg : otp_legacy_only_i;
   assign cfg_rdata_o              = rdata_reg;
   assign charge_port_enable_o     = charge_reg;
   assign port_removable_o         = rmv_eff;
   assign port_enabled_o           = enabled_eff;
   assign custom_attach_override_o = override_reg;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_rmv_write;
      cfg_wr_i && hit(cfg_addr_i, DPCR_REMOVABLE_OFS) && cfg_wdata_i[DPCR_OVERRIDE_BIT]
         && state_reg == DPCR_ST_RUN;
   endsequence

   AST_CHG_UNUSED_ZERO: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      hit($past(cfg_addr_i), DPCR_CHARGE_OFS) |-> cfg_rdata_o[7:4] == 4'h0)
      else $error("Charge register reserved bits not zero");
   AST_RMV_UNUSED_ZERO: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      hit($past(cfg_addr_i), DPCR_REMOVABLE_OFS) |-> cfg_rdata_o[6:4] == 3'h0)
      else $error("Removable register reserved bits not zero");
   AST_STRAP_LOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      state_reg == DPCR_ST_LOAD |=> charge_port_enable_o == $past(strap_sync))
      else $error("Charge enables not loaded from straps");
   AST_CHARGE_WR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (cfg_wr_i && hit(cfg_addr_i, DPCR_CHARGE_OFS) && state_reg == DPCR_ST_RUN)
      |=> charge_port_enable_o == $past(cfg_wdata_i[3:0]))
      else $error("Charge enable write lost");
   AST_OTP_REMOVABLE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !custom_attach_override_o |-> port_removable_o == ~otp_fixed_attach_i)
      else $error("Removable not inverted OTP");
   AST_LOCKED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (!override_reg && cfg_wr_i && hit(cfg_addr_i, DPCR_PORT_USED_OFS))
      |=> used_reg == $past(used_reg))
      else $error("Port-used written while locked");
   AST_JOINT_WR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      s_rmv_write |=> custom_attach_override_o && port_removable_o == $past(cfg_wdata_i[3:0]))
      else $error("Override and removable not set together");
   AST_PORT13: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      port_enabled_o[0] || port_enabled_o[2])
      else $error("Ports one and three both disabled");
endmodule // dpcr_regs

// File: verification/dpcr_cfg_src.sv
// Model of the configuration source that writes and reads the port registers
`timescale 1ns/1ps
module dpcr_cfg_src (
   input  wire logic       core_clk_i,   // Core clock
   input  wire logic [7:0] cfg_rdata_i,  // Registered read data
   output logic            cfg_wr_o,     // Write strobe
   output logic      [7:0] cfg_addr_o,   // Register offset
   output logic      [7:0] cfg_wdata_o   // Write data
);
   // -----------------------------------------------------------------
   // Idle levels at time zero
   // -----------------------------------------------------------------
   initial begin
      cfg_wr_o    = 1'b0;
      cfg_addr_o  = 8'h00;
      cfg_wdata_o = 8'h00;
   end
   // One write; idle cycles first let the source answer slowly
   task automatic write(input logic [7:0] a, input logic [7:0] d, input int idle);
      repeat (idle) @(posedge core_clk_i);
      @(posedge core_clk_i);
      cfg_addr_o  <= a;
      cfg_wdata_o <= d;
      cfg_wr_o    <= 1'b1;
      @(posedge core_clk_i);
      cfg_wr_o    <= 1'b0;
      cfg_wdata_o <= ~d;                  // Stale data must not be relied on
   endtask
   // Read: data registers on the edge after the offset is applied
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      cfg_addr_o <= a;
      @(posedge core_clk_i);
      #1 d = cfg_rdata_i;
   endtask
endmodule // dpcr_cfg_src

// File: verification/testbench.sv
// Self-checking bench for the port configuration registers
`timescale 1ns/1ps
module testbench;
   import dpcr_pkg::*;
   logic       core_clk_i, sys_rst_i, cfg_wr_i, custom_attach_override_o;  // Clock, reset, strobe
   logic [3:0] power_charge_strap_i, otp_fixed_attach_i;                   // Straps, OTP attach
   logic [3:0] otp_port_used_i, otp_legacy_only_i;                         // OTP used, legacy
   logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o;                       // Register access
   logic [3:0] charge_port_enable_o, port_removable_o;                     // Charge, removable
   logic [3:0] port_enabled_o, legacy_speed_only_o;                        // Enable, legacy
   logic       m_ovr;                                                      // Model override
   logic [3:0] m_rem, m_used, m_chg;                                       // Model fields
   int         fails, n_compared;                                          // Counters
   int         cyc = 0;                                                    // Cycle counter
   dpcr_regs i_dpcr_regs (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .power_charge_strap_i(power_charge_strap_i), .otp_fixed_attach_i(otp_fixed_attach_i),
      .otp_port_used_i(otp_port_used_i), .otp_legacy_only_i(otp_legacy_only_i),
      .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .charge_port_enable_o(charge_port_enable_o),
      .port_removable_o(port_removable_o), .port_enabled_o(port_enabled_o),
      .legacy_speed_only_o(legacy_speed_only_o),
      .custom_attach_override_o(custom_attach_override_o));
   dpcr_cfg_src i_dpcr_cfg_src (.core_clk_i(core_clk_i), .cfg_rdata_i(cfg_rdata_o),
      .cfg_wr_o(cfg_wr_i), .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i));
   // -----------------------------------------------------------------
   // Expected values from the model state
   // -----------------------------------------------------------------
   function automatic logic [3:0] exp_rem();
      return m_ovr ? m_rem : ~otp_fixed_attach_i;     // Inverted fixed-attach when locked
   endfunction
   function automatic logic [3:0] exp_used();
      return m_ovr ? m_used : otp_port_used_i;
   endfunction
   function automatic logic [3:0] exp_leg();
      return m_ovr ? 4'h0 : otp_legacy_only_i;        // No write path once unlocked
   endfunction
   function automatic logic [3:0] exp_en();
      logic [3:0] e;
      e = exp_used() | exp_leg();
      if (!e[0] && !e[2]) e[0] = 1'b1;                 // Ports 1 and 3 never both off
      return e;
   endfunction
   // Comparison, counted; mismatch reported at once
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Read back every register and check the outputs
   task automatic check_all();
      logic [7:0] d;
      i_dpcr_cfg_src.read(DPCR_CHARGE_OFS, d);
      chk("charge_reg", d, {4'h0, m_chg});
      i_dpcr_cfg_src.read(DPCR_REMOVABLE_OFS, d);
      chk("removable_reg", d, {m_ovr, 3'h0, exp_rem()});
      i_dpcr_cfg_src.read(DPCR_PORT_USED_OFS, d);
      chk("port_used_reg", d, {4'h0, exp_used()});
      i_dpcr_cfg_src.read(8'h80 | 8'($urandom), d);
      chk("unmapped", d, 8'h00);
      chk("charge_out", {4'h0, charge_port_enable_o}, {4'h0, m_chg});
      chk("removable_out", {4'h0, port_removable_o}, {4'h0, exp_rem()});
      chk("enabled_out", {4'h0, port_enabled_o}, {4'h0, exp_en()});
      chk("legacy_out", {4'h0, legacy_speed_only_o}, {4'h0, exp_leg()});
      chk("override_out", {7'h0, custom_attach_override_o}, {7'h0, m_ovr});
   endtask
   // Write through the source, update the model, check
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int idle);
      i_dpcr_cfg_src.write(a, d, idle);
      if (a == DPCR_CHARGE_OFS) m_chg = d[3:0];
      if (a == DPCR_REMOVABLE_OFS) begin
         m_ovr = d[7];
         if (d[7]) m_rem = d[3:0];                         // Stored bits kept when locking
      end
      if (a == DPCR_PORT_USED_OFS && m_ovr) m_used = d[3:0];
      check_all();
   endtask
   // -----------------------------------------------------------------
   // Clock and cycle ceiling
   // -----------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin                // Tests need fewer than 1400 cycles
         fails++;
         close_out();
      end
   end
   // -----------------------------------------------------------------
   // Main sequence: two rounds, second reset lands mid-run
   // -----------------------------------------------------------------
   initial begin
      sys_rst_i = 1'b1;
      power_charge_strap_i = 4'h0;
      otp_fixed_attach_i = 4'h0;
      otp_port_used_i = 4'h0;
      otp_legacy_only_i = 4'h0;
      fails = 0;
      n_compared = 0;
      void'($urandom(32'h2e6b3909));
      for (int r = 0; r < 2; r++) begin
         @(posedge core_clk_i);
         sys_rst_i <= 1'b1;
         power_charge_strap_i <= 4'($urandom);
         otp_fixed_attach_i <= 4'($urandom);
         otp_port_used_i <= (r == 0) ? 4'h0 : 4'($urandom); // First round forces port 1
         otp_legacy_only_i <= (r == 0) ? 4'h0 : 4'($urandom);
         repeat (8) @(posedge core_clk_i);
         sys_rst_i <= 1'b0;
         {m_ovr, m_rem, m_used} = {1'b0, 4'h0, 4'hf};
         #1 m_chg = power_charge_strap_i;
         // Early write is dropped, straps stay loaded
         i_dpcr_cfg_src.write(DPCR_CHARGE_OFS, {4'h0, ~m_chg}, 0);
         check_all();
         wr(DPCR_CHARGE_OFS, 8'hff, 0);
         wr(DPCR_PORT_USED_OFS, 8'h05, 0);
         wr(DPCR_REMOVABLE_OFS, {4'hf, 4'($urandom)}, 0);
         wr(DPCR_PORT_USED_OFS, 8'hfa, 0);
         wr(DPCR_REMOVABLE_OFS, 8'h0f, 1);
         for (int i = 0; i < 50; i++) begin
            wr(8'(6 + ($urandom % 4)), 8'($urandom), $urandom % 3);
         end
      end
      close_out();
   end
endmodule // testbench
